// >>> logic/sfep_pkg.sv
// Purpose: Shared constants and types for the serial flash erase/program sequencer
// Assumes: Core clock of 20 MHz; host link sampled as plain inputs
// Notes:   Cycle times are plain defaults; real parts differ
package sfep_pkg;
  localparam logic [7:0] CMD_WRITE_ENABLE     = 8'h06;
  localparam logic [7:0] CMD_PAGE_ERASE       = 8'h81;
  localparam logic [7:0] CMD_SECTOR_ERASE     = 8'h20;
  localparam logic [7:0] CMD_HALF_BLOCK_ERASE = 8'h52;
  localparam logic [7:0] CMD_FULL_BLOCK_ERASE = 8'hd8;
  localparam logic [7:0] CMD_CHIP_ERASE_A     = 8'h60;
  localparam logic [7:0] CMD_CHIP_ERASE_B     = 8'hc7;
  localparam logic [7:0] CMD_SINGLE_PROGRAM   = 8'h02;
  localparam logic [7:0] CMD_TWO_LINE_PROGRAM = 8'ha2;

  // Erase size codes shown on ERASE_SIZE
  localparam logic [2:0] ERASE_PAGE       = 3'h0;
  localparam logic [2:0] ERASE_SECTOR     = 3'h1;
  localparam logic [2:0] ERASE_HALF_BLOCK = 3'h2;
  localparam logic [2:0] ERASE_FULL_BLOCK = 3'h3;
  localparam logic [2:0] ERASE_CHIP       = 3'h4;

  localparam int unsigned ADDR_W       = 24;
  localparam int unsigned PAGE_LSB     = 8;
  localparam int unsigned SECTOR_LSB   = 12;
  localparam int unsigned HALF_LSB     = 15;
  localparam int unsigned FULL_LSB     = 16;
  localparam int unsigned BLOCK_IDX_W  = 5;
  localparam logic [1:0]  LAST_ADDR_BYTE = 2'h2;
  localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;

  // Cycle times in microseconds and the core clock in MHz
  localparam int unsigned CLK_MHZ                = 20;
  localparam int unsigned PAGE_ERASE_TIME_US     = 2000;
  localparam int unsigned SECTOR_ERASE_TIME_US   = 4000;
  localparam int unsigned HALF_BLOCK_ERASE_TIME_US = 8000;
  localparam int unsigned FULL_BLOCK_ERASE_TIME_US = 12000;
  localparam int unsigned ARRAY_ERASE_TIME_US    = 50000;
  localparam int unsigned PAGE_PROGRAM_TIME_US   = 1000;

  typedef enum logic [1:0] {PH_OPCODE, PH_ADDRESS, PH_DATA, PH_TRAIL} sfep_phase_t;
  typedef enum logic [1:0] {EX_IDLE, EX_PROGRAM, EX_WAIT} sfep_exec_t;
endpackage

// >>> logic/sfep_sync.sv
// Purpose: Two-stage synchroniser for link pins
// Assumes: Inputs are asynchronous to clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module sfep_sync #(
  parameter int unsigned W = 4
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        meta_q[i] <= 1'b1;
        q[i]      <= 1'b1;
      end else begin
        meta_q[i] <= d[i];
        q[i]      <= meta_q[i];
      end
    end
  end
endmodule // sfep_sync
`default_nettype wire

// >>> logic/sfep_timer.sv
// Purpose: Down counter that times a self-timed array cycle
// Assumes: load is a single-cycle pulse
// Notes:   done pulses one cycle after the count runs out
`timescale 1ns/10ps
`default_nettype none
module sfep_timer #(
  parameter int unsigned W = 32
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              done
);
  logic [W-1:0] cnt_q;
  logic         run_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        cnt_q <= load_val;
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q <= W'(1)) begin
          run_q <= 1'b0;
          done  <= 1'b1;
        end else begin
          cnt_q <= cnt_q - W'(1);
        end
      end
    end
  end
endmodule // sfep_timer
`default_nettype wire

// >>> logic/sfep_top.sv
// Purpose: Erase and page-program command handling of a serial NOR flash
// Assumes: Host drives CS_N, SCLK, IO lines; array sits outside and applies strobes
// Notes:   Program strobes only clear bits; the array ANDs PROG_DATA into memory
`timescale 1ns/10ps
`default_nettype none
module sfep_top #(
  parameter int unsigned PAGE_ERASE_CYC   = sfep_pkg::PAGE_ERASE_TIME_US * sfep_pkg::CLK_MHZ,
  parameter int unsigned SECTOR_ERASE_CYC = sfep_pkg::SECTOR_ERASE_TIME_US * sfep_pkg::CLK_MHZ,
  parameter int unsigned HALF_ERASE_CYC   = sfep_pkg::HALF_BLOCK_ERASE_TIME_US * sfep_pkg::CLK_MHZ,
  parameter int unsigned FULL_ERASE_CYC   = sfep_pkg::FULL_BLOCK_ERASE_TIME_US * sfep_pkg::CLK_MHZ,
  parameter int unsigned CHIP_ERASE_CYC   = sfep_pkg::ARRAY_ERASE_TIME_US * sfep_pkg::CLK_MHZ,
  parameter int unsigned PROGRAM_CYC      = sfep_pkg::PAGE_PROGRAM_TIME_US * sfep_pkg::CLK_MHZ
) (
  input  wire logic                          CORE_CLK,
  input  wire logic                          RSTN,
  input  wire logic                          CS_N,
  input  wire logic                          SCLK,
  input  wire logic                          IO_LINE_0,
  input  wire logic                          IO_LINE_1,
  input  wire logic [2:0]                    UPPER_IO_LINES,
  input  wire logic [4:0]                    PROTECT_BITS,
  output logic                               WRITE_ENABLE_LATCH,
  output logic                               WRITE_IN_PROGRESS,
  output logic                               READ_REJECT,
  output logic                               ERASE_STB,
  output logic [2:0]                         ERASE_SIZE,
  output logic [sfep_pkg::ADDR_W-1:0]        ERASE_ADDR,
  output logic                               PROG_STB,
  output logic [sfep_pkg::ADDR_W-1:0]        PROG_ADDR,
  output logic [7:0]                         PROG_DATA
);
  localparam int unsigned AW = sfep_pkg::ADDR_W;

  logic [3:0]           sync_q;
  logic                 cs_n_s, sclk_s, io1_s, io0_s;
  logic                 sclk_prev_q, cs_prev_q;
  logic                 sclk_rise, frame_end;
  sfep_pkg::sfep_phase_t phase_q;
  logic [7:0]           shift_q, opc_q, new_byte;
  logic [2:0]           bit_q;
  logic [3:0]           bit_sum;
  logic                 byte_done, dual_q;
  logic [AW-1:0]        addr_q;
  logic [1:0]           addr_cnt_q;
  logic                 data_seen_q, trail_q;
  logic [7:0]           ptr_q;
  logic [7:0]           buf_mem [256];
  logic [255:0]         valid_q;
  logic                 wel_q, wip_q;
  sfep_pkg::sfep_exec_t ex_q;
  logic [7:0]           idx_q;
  logic [AW-1:0]        page_q;
  logic                 is_prog_opc, prog_ok;
  logic                 start_erase, start_prog, wel_set, wel_drop;
  logic [2:0]           erase_size;
  logic [AW-1:0]        erase_addr;
  logic [31:0]          erase_cyc;
  logic                 timer_load, timer_done;
  logic [31:0]          timer_val;

  // SCLK is oversampled; the host clock must stay well below a quarter of CORE_CLK
  sfep_sync #(.W(4)) u_sync (
    .clk   (CORE_CLK),
    .rst_n (RSTN),
    .d     ({CS_N, SCLK, IO_LINE_1, IO_LINE_0}),
    .q     (sync_q)
  );
  assign cs_n_s = sync_q[3];
  assign sclk_s = sync_q[2];
  assign io1_s  = sync_q[1];
  assign io0_s  = sync_q[0];

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q   <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s;
      cs_prev_q   <= cs_n_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_prev_q & ~cs_n_s;
  assign frame_end = cs_n_s & ~cs_prev_q;

  // Upper lines never reach the shifter, so their levels cannot matter
  always_comb begin
    if (dual_q && phase_q == sfep_pkg::PH_DATA) begin
      new_byte = {shift_q[5:0], io1_s, io0_s};
      bit_sum  = {1'b0, bit_q} + 4'h2;
    end else begin
      new_byte = {shift_q[6:0], io0_s};
      bit_sum  = {1'b0, bit_q} + 4'h1;
    end
  end
  assign byte_done = sclk_rise && (bit_sum == sfep_pkg::BITS_PER_BYTE);

  assign is_prog_opc = (opc_q == sfep_pkg::CMD_SINGLE_PROGRAM) || (opc_q == sfep_pkg::CMD_TWO_LINE_PROGRAM);

  // Frame parsing; state is cleared while CS_N is high, after frame_end has seen it
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      phase_q     <= sfep_pkg::PH_OPCODE;
      shift_q     <= 8'h00;
      bit_q       <= 3'h0;
      opc_q       <= 8'h00;
      dual_q      <= 1'b0;
      addr_q      <= '0;
      addr_cnt_q  <= 2'h0;
      data_seen_q <= 1'b0;
      trail_q     <= 1'b0;
    end else if (cs_n_s) begin
      phase_q     <= sfep_pkg::PH_OPCODE;
      bit_q       <= 3'h0;
      dual_q      <= 1'b0;
      addr_cnt_q  <= 2'h0;
      data_seen_q <= 1'b0;
      trail_q     <= 1'b0;
    end else if (sclk_rise) begin
      shift_q <= new_byte;
      bit_q   <= bit_sum[2:0];
      if (byte_done) begin
        case (phase_q)
          sfep_pkg::PH_OPCODE: begin
            opc_q  <= new_byte;
            dual_q <= (new_byte == sfep_pkg::CMD_TWO_LINE_PROGRAM);
            if (new_byte == sfep_pkg::CMD_WRITE_ENABLE || new_byte == sfep_pkg::CMD_CHIP_ERASE_A ||
                new_byte == sfep_pkg::CMD_CHIP_ERASE_B) begin
              phase_q <= sfep_pkg::PH_TRAIL;
            end else begin
              phase_q <= sfep_pkg::PH_ADDRESS;
            end
          end
          sfep_pkg::PH_ADDRESS: begin
            addr_q     <= {addr_q[AW-9:0], new_byte};
            addr_cnt_q <= addr_cnt_q + 2'h1;
            if (addr_cnt_q == sfep_pkg::LAST_ADDR_BYTE) begin
              phase_q <= sfep_pkg::PH_DATA;
            end
          end
          sfep_pkg::PH_DATA: begin
            data_seen_q <= 1'b1;
          end
          sfep_pkg::PH_TRAIL: begin
            trail_q <= 1'b1;
          end
          default: begin
            phase_q <= sfep_pkg::PH_OPCODE;
          end
        endcase
      end
    end
  end

  // Program buffer: pointer starts at the low address byte and wraps in the page
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ptr_q   <= 8'h00;
      valid_q <= '0;
    end else if (!wip_q && !cs_n_s && byte_done) begin
      if (phase_q == sfep_pkg::PH_OPCODE) begin
        valid_q <= '0;
      end else if (phase_q == sfep_pkg::PH_ADDRESS) begin
        ptr_q <= new_byte;
      end else if (phase_q == sfep_pkg::PH_DATA && is_prog_opc) begin
        valid_q[ptr_q] <= 1'b1;
        ptr_q          <= ptr_q + 8'h01;
      end
    end
  end

  // Later bytes overwrite earlier ones at the same offset, keeping the last 256
  always_ff @(posedge CORE_CLK) begin
    if (!wip_q && !cs_n_s && byte_done && phase_q == sfep_pkg::PH_DATA && is_prog_opc) begin
      buf_mem[ptr_q] <= new_byte;
    end
  end

  // Top protection when bit 3 is clear, bottom when set; a field of 7 covers all
  function automatic logic covered(input logic [AW-1:0] a, input logic [4:0] bp);
    logic [sfep_pkg::BLOCK_IDX_W-1:0] blk;
    logic [sfep_pkg::BLOCK_IDX_W:0]   span;
    blk  = a[sfep_pkg::FULL_LSB +: sfep_pkg::BLOCK_IDX_W];
    span = (sfep_pkg::BLOCK_IDX_W+1)'(1) << (bp[2:0] - 3'h1);
    if (bp[2:0] == 3'h0) begin
      covered = 1'b0;
    end else if (bp[2:0] == 3'h7) begin
      covered = 1'b1;
    end else if (bp[3]) begin
      covered = {1'b0, blk} < span;
    end else begin
      covered = {1'b0, blk} >= ((sfep_pkg::BLOCK_IDX_W+1)'(1) << sfep_pkg::BLOCK_IDX_W) - span;
    end
  endfunction

  // Decode the finished frame; only an idle device acts, and all but write enable need the latch set
  always_comb begin
    start_erase = 1'b0;
    start_prog  = 1'b0;
    wel_set     = 1'b0;
    wel_drop    = 1'b0;
    erase_size  = sfep_pkg::ERASE_PAGE;
    erase_addr  = '0;
    erase_cyc   = 32'(PAGE_ERASE_CYC);
    prog_ok     = (phase_q == sfep_pkg::PH_DATA) && data_seen_q && (bit_q == 3'h0);
    if (frame_end && !wip_q) begin
      if (phase_q == sfep_pkg::PH_DATA && !data_seen_q && bit_q == 3'h0 && wel_q) begin
        case (opc_q)
          sfep_pkg::CMD_PAGE_ERASE: begin
            erase_size  = sfep_pkg::ERASE_PAGE;
            // Top two bytes name the page, the last byte is a dummy
            erase_addr  = {addr_q[AW-1:sfep_pkg::PAGE_LSB], 8'h00};
            erase_cyc   = 32'(PAGE_ERASE_CYC);
            start_erase = !covered(addr_q, PROTECT_BITS);
          end
          sfep_pkg::CMD_SECTOR_ERASE: begin
            erase_size  = sfep_pkg::ERASE_SECTOR;
            erase_addr  = {addr_q[AW-1:sfep_pkg::SECTOR_LSB], 12'h000};
            erase_cyc   = 32'(SECTOR_ERASE_CYC);
            start_erase = !covered(addr_q, PROTECT_BITS);
          end
          sfep_pkg::CMD_HALF_BLOCK_ERASE: begin
            erase_size  = sfep_pkg::ERASE_HALF_BLOCK;
            erase_addr  = {addr_q[AW-1:sfep_pkg::HALF_LSB], 15'h0000};
            erase_cyc   = 32'(HALF_ERASE_CYC);
            start_erase = !covered(addr_q, PROTECT_BITS);
            wel_drop    = covered(addr_q, PROTECT_BITS);
          end
          sfep_pkg::CMD_FULL_BLOCK_ERASE: begin
            erase_size  = sfep_pkg::ERASE_FULL_BLOCK;
            erase_addr  = {addr_q[AW-1:sfep_pkg::FULL_LSB], 16'h0000};
            erase_cyc   = 32'(FULL_ERASE_CYC);
            start_erase = !covered(addr_q, PROTECT_BITS);
          end
          default: begin
            start_erase = 1'b0;
          end
        endcase
      end else if (phase_q == sfep_pkg::PH_TRAIL && !trail_q && bit_q == 3'h0) begin
        if (opc_q == sfep_pkg::CMD_WRITE_ENABLE) begin
          wel_set = 1'b1;
        end else if (wel_q) begin
          erase_size  = sfep_pkg::ERASE_CHIP;
          erase_cyc   = 32'(CHIP_ERASE_CYC);
          start_erase = (PROTECT_BITS == 5'h00);
        end
      end else if (prog_ok && is_prog_opc && wel_q) begin
        start_prog = !covered(addr_q, PROTECT_BITS);
      end
    end
  end

  // Erase strobe is a pulse with its size and base address held in flops
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ERASE_STB  <= 1'b0;
      ERASE_SIZE <= sfep_pkg::ERASE_PAGE;
      ERASE_ADDR <= '0;
    end else begin
      ERASE_STB <= start_erase;
      if (start_erase) begin
        ERASE_SIZE <= erase_size;
        ERASE_ADDR <= erase_addr;
      end
    end
  end

  // Cycle sequencing: program walks the buffer, then both wait on the timer
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ex_q      <= sfep_pkg::EX_IDLE;
      idx_q     <= 8'h00;
      page_q    <= '0;
      PROG_STB  <= 1'b0;
      PROG_ADDR <= '0;
      PROG_DATA <= 8'hff;
    end else begin
      PROG_STB <= 1'b0;
      case (ex_q)
        sfep_pkg::EX_IDLE: begin
          idx_q <= 8'h00;
          if (start_prog) begin
            ex_q   <= sfep_pkg::EX_PROGRAM;
            page_q <= {addr_q[AW-1:sfep_pkg::PAGE_LSB], 8'h00};
          end else if (start_erase) begin
            ex_q <= sfep_pkg::EX_WAIT;
          end
        end
        sfep_pkg::EX_PROGRAM: begin
          // Only offsets that received data are strobed
          if (valid_q[idx_q]) begin
            PROG_STB  <= 1'b1;
            PROG_ADDR <= {page_q[AW-1:sfep_pkg::PAGE_LSB], idx_q};
            PROG_DATA <= buf_mem[idx_q];
          end
          idx_q <= idx_q + 8'h01;
          if (idx_q == 8'hff) begin
            ex_q <= sfep_pkg::EX_WAIT;
          end
        end
        sfep_pkg::EX_WAIT: begin
          if (timer_done) begin
            ex_q <= sfep_pkg::EX_IDLE;
          end
        end
        default: begin
          ex_q <= sfep_pkg::EX_IDLE;
        end
      endcase
    end
  end

  // Program time runs alongside the buffer walk, which is far shorter
  assign timer_load = start_erase | start_prog;
  assign timer_val  = start_prog ? 32'(PROGRAM_CYC) : erase_cyc;

  sfep_timer #(.W(32)) u_timer (
    .clk      (CORE_CLK),
    .rst_n    (RSTN),
    .load     (timer_load),
    .load_val (timer_val),
    .done     (timer_done)
  );

  // Status flags; the latch cannot be set while a cycle runs
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      wip_q <= 1'b0;
      wel_q <= 1'b0;
    end else begin
      if (timer_load) begin
        wip_q <= 1'b1;
      end else if (timer_done && ex_q == sfep_pkg::EX_WAIT) begin
        wip_q <= 1'b0;
      end
      if (wel_set) begin
        wel_q <= 1'b1;
      end else if (wel_drop || (timer_done && ex_q == sfep_pkg::EX_WAIT)) begin
        wel_q <= 1'b0;
      end
    end
  end

  assign WRITE_IN_PROGRESS  = wip_q;
  assign WRITE_ENABLE_LATCH = wel_q;
  assign READ_REJECT        = wip_q;

endmodule // sfep_top
`default_nettype wire

// >>> verification/sfep_host.sv
// Purpose: Host controller model that sends frames on the flash link
// Assumes: Caller sits on a rising core edge; link clock is 8 core cycles
// Notes:   Link clock stands low between frames; data lines invert on release
`timescale 1ns/10ps
`default_nettype none
module sfep_host (
  input  wire logic       clk,
  output logic            cs_n,
  output logic            sclk,
  output logic            io0,
  output logic            io1,
  output logic [2:0]      upper
);
  initial begin
    cs_n  = 1'b1;
    sclk  = 1'b0;
    io0   = 1'b0;
    io1   = 1'b0;
    upper = 3'h0;
  end
  // Upper lines wander all the time so a design that samples them shows it
  always @(posedge clk) upper <= {upper[1:0], ~upper[2]};
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bit_out(input logic b1, input logic b0);
    io1  <= b1;
    io0  <= b0;
    tick(4);
    sclk <= 1'b1;
    tick(4);
    sclk <= 1'b0;
  endtask
  // Bytes from dual_from on go two bits a clock, high pair first
  task automatic frame(input logic [7:0] q[$], input int dual_from, input int extra);
    int j;
    cs_n <= 1'b0;
    tick(4);
    foreach (q[i]) begin
      if (i >= dual_from) for (j = 6; j >= 0; j -= 2) bit_out(q[i][j+1], q[i][j]);
      else for (j = 7; j >= 0; j--) bit_out(1'b0, q[i][j]);
    end
    repeat (extra) bit_out(1'b0, 1'b1);
    tick(4);
    cs_n <= 1'b1;
    io0  <= ~io0;
    io1  <= ~io1;
    tick(8);
  endtask
endmodule // sfep_host
`default_nettype wire

// >>> verification/sfep_chk_sva.sv
// Purpose: Port checks for the erase and program sequencer
// Assumes: One clock domain; program is the shortest timed cycle
// Notes:   Bound to every instance of the top module
`timescale 1ns/10ps
`default_nettype none
module sfep_chk #(
  parameter int unsigned PROGRAM_CYC    = 300,
  parameter int unsigned CHIP_ERASE_CYC = 300
) (
  input wire logic        CORE_CLK,
  input wire logic        RSTN,
  input wire logic [4:0]  PROTECT_BITS,
  input wire logic        WRITE_ENABLE_LATCH,
  input wire logic        WRITE_IN_PROGRESS,
  input wire logic        READ_REJECT,
  input wire logic        ERASE_STB,
  input wire logic [2:0]  ERASE_SIZE,
  input wire logic [23:0] ERASE_ADDR,
  input wire logic        PROG_STB
);
  logic [31:0] wip_cnt_q;
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) wip_cnt_q <= 32'h0;
    else wip_cnt_q <= WRITE_IN_PROGRESS ? wip_cnt_q + 32'h1 : 32'h0;
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  rej_mirror_a: assert property (READ_REJECT == WRITE_IN_PROGRESS)
    else $error("read reject differs from busy flag");
  erase_busy_a: assert property (ERASE_STB |-> WRITE_IN_PROGRESS ##1 !ERASE_STB)
    else $error("erase strobe without busy or too long");
  prog_busy_a: assert property (PROG_STB |-> WRITE_IN_PROGRESS && !ERASE_STB)
    else $error("program strobe outside busy cycle");
  start_wel_a: assert property ($rose(WRITE_IN_PROGRESS) |-> WRITE_ENABLE_LATCH)
    else $error("cycle started without latch");
  end_wel_a: assert property ($fell(WRITE_IN_PROGRESS) |-> !WRITE_ENABLE_LATCH)
    else $error("latch kept after cycle");
  wel_drop_a: assert property ($fell(WRITE_ENABLE_LATCH) |-> !WRITE_IN_PROGRESS)
    else $error("latch dropped during cycle");
  chip_prot_a: assert property (ERASE_STB && ERASE_SIZE == 3'h4 |-> PROTECT_BITS == 5'h00)
    else $error("chip erase while protected");
  sector_align_a: assert property (ERASE_STB && ERASE_SIZE == 3'h1 |-> ERASE_ADDR[11:0] == 12'h000)
    else $error("sector base not aligned");
  wip_len_a: assert property ($fell(WRITE_IN_PROGRESS) |->
    wip_cnt_q >= PROGRAM_CYC && wip_cnt_q <= CHIP_ERASE_CYC + 3) else $error("busy length out of range");
  c_chip: cover property (ERASE_STB && ERASE_SIZE == 3'h4);
  c_prog: cover property (PROG_STB);
  c_drop: cover property ($fell(WRITE_ENABLE_LATCH) && !WRITE_IN_PROGRESS);
endmodule // sfep_chk
bind sfep_top sfep_chk #(.PROGRAM_CYC(PROGRAM_CYC), .CHIP_ERASE_CYC(CHIP_ERASE_CYC)) u_chk (
  .CORE_CLK(CORE_CLK), .RSTN(RSTN), .PROTECT_BITS(PROTECT_BITS), .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH),
  .WRITE_IN_PROGRESS(WRITE_IN_PROGRESS), .READ_REJECT(READ_REJECT), .ERASE_STB(ERASE_STB),
  .ERASE_SIZE(ERASE_SIZE), .ERASE_ADDR(ERASE_ADDR), .PROG_STB(PROG_STB));
`default_nettype wire

// >>> verification/tb.sv
// Purpose: Self-checking bench for the erase and program sequencer
// Assumes: Timed cycles shortened to 300..340 core cycles, one count per erase size
// Notes:   Array is modelled by recording the strobes
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [4:0]  prot = 5'h00;
  logic        cs_n, sclk, io0, io1, write_enable_latch, write_in_progress, rrej, estb, pstb;
  logic [2:0]  upper, esize;
  logic [23:0] eaddr, paddr;
  logic [7:0]  pdata;
  logic [7:0]  pdat [256];
  logic [15:0] ppage;
  int          err_count = 0, compares = 0, ecnt = 0, pcnt = 0;
  int          wrun = 0, wlen = 0;
  // Distinct counts so a size that picks the wrong timer value shows up
  localparam int unsigned PE_CYC = 300, SE_CYC = 310, HB_CYC = 320, FB_CYC = 330, CE_CYC = 340, PP_CYC = 300;
  always #25 clk = ~clk;
  sfep_host host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .io0(io0), .io1(io1), .upper(upper));
  sfep_top #(.PAGE_ERASE_CYC(PE_CYC), .SECTOR_ERASE_CYC(SE_CYC), .HALF_ERASE_CYC(HB_CYC),
    .FULL_ERASE_CYC(FB_CYC), .CHIP_ERASE_CYC(CE_CYC), .PROGRAM_CYC(PP_CYC)) dut (.CORE_CLK(clk), .RSTN(rstn),
    .CS_N(cs_n), .SCLK(sclk),
    .IO_LINE_0(io0), .IO_LINE_1(io1), .UPPER_IO_LINES(upper), .PROTECT_BITS(prot), .WRITE_ENABLE_LATCH(write_enable_latch),
    .WRITE_IN_PROGRESS(write_in_progress), .READ_REJECT(rrej), .ERASE_STB(estb), .ERASE_SIZE(esize), .ERASE_ADDR(eaddr),
    .PROG_STB(pstb), .PROG_ADDR(paddr), .PROG_DATA(pdata));
  always @(posedge clk) begin
    // Busy length of the last cycle, in core edges
    if (write_in_progress === 1'b1) wrun++;
    else if (wrun != 0) begin
      wlen = wrun;
      wrun = 0;
    end
    if (estb === 1'b1) ecnt++;
    if (pstb === 1'b1) begin
      pcnt++;
      pdat[paddr[7:0]] = pdata;
      ppage = paddr[23:8];
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic write_enable_cmd;
    host.frame('{8'h06}, 99, 0);
    chk(write_enable_latch, 1'b1);
  endtask
  task automatic wait_wip(input logic lvl);
    int n;
    for (n = 0; n < 1000 && write_in_progress !== lvl; n++) @(posedge clk);
    chk(write_in_progress, lvl);
  endtask
  task automatic t_erase;
    logic [7:0]  op [6] = '{8'h81, 8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7};
    logic [2:0]  sz [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4};
    logic [23:0] bs [6] = '{24'h123400, 24'h123000, 24'h120000, 24'h120000, 24'h0, 24'h0};
    int unsigned cy [6] = '{PE_CYC, SE_CYC, HB_CYC, FB_CYC, CE_CYC, CE_CYC};
    int e0;
    for (int k = 0; k < 6; k++) begin
      e0 = ecnt;
      write_enable_cmd;
      if (k < 4) host.frame('{op[k], 8'h12, 8'h34, 8'h56}, 99, 0);
      else host.frame('{op[k]}, 99, 0);
      chk(ecnt - e0, 1);
      chk(esize, sz[k]);
      chk(eaddr, bs[k]);
      wait_wip(1'b0);
      chk(write_enable_latch, 1'b0);
      @(posedge clk);
      chk(wlen >= cy[k] && wlen <= cy[k] + 2, 1);
    end
    $display("test erase done");
  endtask
  task automatic t_reject;
    int e0 = ecnt;
    int p0 = pcnt;
    host.frame('{8'h20, 8'h00, 8'h10, 8'h00}, 99, 0);
    chk(write_in_progress, 1'b0);
    write_enable_cmd;
    host.frame('{8'h20, 8'h00, 8'h10, 8'h00}, 99, 1);
    host.frame('{8'h02, 8'h00, 8'h00, 8'h00, 8'h55}, 99, 3);
    host.frame('{8'h02, 8'h00, 8'h01, 8'h00}, 99, 0);
    chk(write_enable_latch, 1'b1);
    prot <= 5'h01;
    host.frame('{8'h52, 8'h1f, 8'h80, 8'h00}, 99, 0);
    chk(write_enable_latch, 1'b0);
    write_enable_cmd;
    host.frame('{8'hd8, 8'h1f, 8'h00, 8'h00}, 99, 0);
    host.frame('{8'h60}, 99, 0);
    host.frame('{8'h02, 8'h1f, 8'h00, 8'h00, 8'h12}, 99, 0);
    chk(ecnt - e0, 0);
    chk(pcnt - p0, 0);
    chk(write_in_progress, 1'b0);
    host.frame('{8'hd8, 8'h00, 8'h00, 8'h00}, 99, 0);
    chk(ecnt - e0, 1);
    wait_wip(1'b0);
    prot <= 5'h00;
    $display("test reject done");
  endtask
  task automatic t_prog;
    int p0 = pcnt;
    write_enable_cmd;
    host.frame('{8'h02, 8'h0a, 8'h00, 8'hfe, 8'h11, 8'h22, 8'h33}, 99, 0);
    chk(rrej, 1'b1);
    chk(write_in_progress, 1'b1);
    wait_wip(1'b0);
    chk(pcnt - p0, 3);
    chk({pdat[8'hfe], pdat[8'hff], pdat[8'h00]}, 24'h112233);
    chk(ppage, 16'h0a00);
    chk(write_enable_latch, 1'b0);
    $display("test program done");
  endtask
  task automatic t_dual;
    logic [7:0] q[$] = '{8'ha2, 8'h0b, 8'h00, 8'h00};
    int p0 = pcnt;
    for (int k = 0; k < 257; k++) q.push_back(k < 256 ? k[7:0] : 8'hff);
    write_enable_cmd;
    host.frame(q, 4, 0);
    wait_wip(1'b0);
    chk(pcnt - p0, 256);
    for (int k = 0; k < 256; k++) chk(pdat[k], k == 0 ? 8'hff : k[7:0]);
    $display("test dual program done");
  endtask
  task automatic summarize;
    $display("compares %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    chk({write_enable_latch, write_in_progress, estb, pstb}, 4'h0);
    t_erase;
    t_reject;
    t_prog;
    t_dual;
    summarize;
  end
  initial begin
    #(60000 * 50);
    err_count++;
    summarize;
  end
endmodule // tb
`default_nettype wire
